//--- hw/srsb_cmd_dec.sv
`timescale 1ns/1ps
// Bus command decode against the switch address
module srsb_cmd_dec (
   input  wire logic                 clk_sys_i,
   input  wire logic                 sys_rst_i,
   input  wire srsb_pkg::srsb_cmd_t  cmd_i,
   input  wire logic [4:0]           addr_i,
   output srsb_pkg::srsb_dec_t       dec_o
);
   logic [2:0] grp;
   logic [4:0] sub;
   logic       hit;

   // Split the byte into group and address
   always_comb begin
      grp = cmd_i.code[7:5];
      sub = cmd_i.code[4:0];
      hit = (sub == addr_i);
   end

   // R13: PPE, PPC codes fall through
   // R16: talker, listener, poll and clear codes only
   always_comb begin
      dec_o = '0;
      if (cmd_i.valid) begin
         dec_o.untalk     = (cmd_i.code == srsb_pkg::CMD_UNT);
         dec_o.unlisten   = (cmd_i.code == srsb_pkg::CMD_UNL);
         dec_o.my_talk    = (grp == srsb_pkg::GRP_TALK) && hit;
         dec_o.other_talk = (grp == srsb_pkg::GRP_TALK) && !hit
                            && !dec_o.untalk;
         dec_o.my_listen  = (grp == srsb_pkg::GRP_LISTEN) && hit;
         dec_o.spe        = (cmd_i.code == srsb_pkg::CMD_SPE);
         dec_o.spd        = (cmd_i.code == srsb_pkg::CMD_SPD);
         dec_o.dev_clear  = (cmd_i.code == srsb_pkg::CMD_DCL);
         dec_o.sel_clear  = (cmd_i.code == srsb_pkg::CMD_SDC);
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   property p_dec_excl;
      dec_o.my_talk |-> !dec_o.other_talk && !dec_o.untalk;
   endproperty
   a_dec_excl: assert property (p_dec_excl) // R16
      else $error("talk decode not exclusive");
endmodule

//--- hw/srsb_pkg.sv
// Summary of operation
// R1: Serial poll answer is one 8-bit byte.
// R2: Bits 1,2,3 conditions, bit 7 summary.
// R3: Enabled present condition sets bit, summary, SRQ.
// R4: Disabled condition sets nothing, no SRQ.
// R5: Invalid command error always requests service.
// R6: Data ready, displayed error need enables.
// R7: Set bits stay until whole word cleared.
// R8: Word frozen while serial poll mode active.
// R9: Talk addressed in poll mode sends word.
// R10: After sending, SPD, Abort, untalk clear word.
// R11: Clear message clears word and request.
// R12: Talk-only output byte clears the word.
// R13: Parallel poll ignored, never driven.
// R14: IFC drops talker, listener, transfer.
// R15: Five-bit switch address, default 28.
// R16: Talker, listener, SR1, DC1; no PP, controller.
// R17: SRQ released before word goes out.
// R18: Clear message resets the condition enables.
// R19: Data ready means output data pending.
// R20: Displayed error includes invalid command error.
// R21: Reset clears word, SRQ, poll mode.
package srsb_pkg;
   localparam int unsigned ADDR_W       = 5;
   localparam logic [4:0]  ADDR_DEFAULT = 5'h1C;
   localparam int unsigned BIT_DATA_RDY = 0;
   localparam int unsigned BIT_CMD_ERR  = 1;
   localparam int unsigned BIT_DISP_ERR = 2;
   localparam int unsigned BIT_RQS      = 6;
   localparam logic [7:0]  STATUS_RESET = 8'h00;
   localparam logic [7:0]  STATUS_MASK  = 8'h47;
   // Bus command bytes seen with ATN true
   localparam logic [7:0]  CMD_SDC      = 8'h04;
   localparam logic [7:0]  CMD_DCL      = 8'h14;
   localparam logic [7:0]  CMD_SPE      = 8'h18;
   localparam logic [7:0]  CMD_SPD      = 8'h19;
   localparam logic [7:0]  CMD_UNL      = 8'h3F;
   localparam logic [7:0]  CMD_UNT      = 8'h5F;
   localparam logic [2:0]  GRP_LISTEN   = 3'h1;
   localparam logic [2:0]  GRP_TALK     = 3'h2;

   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } srsb_cmd_t;

   typedef struct packed {
      logic data_ready;
      logic cmd_error;
      logic disp_error;
   } srsb_cond_t;

   typedef struct packed {
      logic my_talk;
      logic other_talk;
      logic untalk;
      logic my_listen;
      logic unlisten;
      logic spe;
      logic spd;
      logic dev_clear;
      logic sel_clear;
   } srsb_dec_t;

   typedef enum logic {
      TALK_IDLE,
      TALK_ADDR
   } srsb_talk_t;
endpackage

//--- hw/srsb_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser, one stage pair per bit
module srsb_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_sys_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta_reg;
         logic sync_reg;
         // First stage feeds only the second
         always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
            end else begin
               meta_reg <= async_i[g];
               sync_reg <= meta_reg;
            end
         end
         assign sync_o[g] = sync_reg;
      end
   endgenerate
endmodule

//--- hw/srsb_top.sv
`timescale 1ns/1ps
module srsb_top (
   input  wire logic                 clk_sys_i,
   input  wire logic                 sys_rst_i,
   input  wire srsb_pkg::srsb_cmd_t  cmd_i,
   input  wire logic                 ifc_i,
   input  wire logic [4:0]           addr_sw_i,
   input  wire logic                 talk_only_i,
   input  wire srsb_pkg::srsb_cond_t cond_i,
   input  wire logic                 enable_wr_i,
   input  wire logic                 enable_data_rdy_i,
   input  wire logic                 enable_disp_err_i,
   input  wire logic                 byte_sent_i,
   input  wire logic                 data_out_i,
   output logic [7:0]                status_byte_o,
   output logic                      status_valid_o,
   output logic                      talker_o,
   output logic                      listener_o,
   output logic                      spoll_mode_o,
   output logic                      srq_o,
   output logic                      srq_oe_o,
   output logic                      ppoll_oe_o
);
   logic [4:0]          addr_sync;
   logic [4:0]          addr_reg;
   logic [4:0]          addr_next;
   logic                ifc_sync;
   logic                tonly_sync;
   logic                strap_done_reg;
   srsb_pkg::srsb_dec_t dec;

   srsb_pkg::srsb_talk_t talk_reg;
   srsb_pkg::srsb_talk_t talk_next;
   logic                 listen_reg;
   logic                 listen_next;
   logic                 spms_reg;
   logic                 spms_next;
   logic                 sent_reg;
   logic                 sent_next;
   logic [7:0]           status_reg;
   logic [7:0]           status_next;
   logic                 en_dr_reg;
   logic                 en_dr_next;
   logic                 en_de_reg;
   logic                 en_de_next;
   logic                 srq_oe_reg;
   logic                 srq_oe_next;
   logic [7:0]           out_reg;
   logic                 outv_reg;
   logic                 outv_next;

   logic [7:0] set_vec;
   logic       clr_all;
   logic       clr_after;
   logic       clear_msg;

   // Pins cross into the clock domain first
   srsb_sync #(
      .W (7)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .async_i   ({ifc_i, talk_only_i, addr_sw_i}),
      .sync_o    ({ifc_sync, tonly_sync, addr_sync})
   );

   // R15: switch address, live after sync
   always_comb begin
      addr_next = addr_reg;
      if (strap_done_reg) begin
         addr_next = addr_sync;
      end
   end

   // Address holds the factory value until sampled
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr_reg       <= srsb_pkg::ADDR_DEFAULT;
         strap_done_reg <= 1'b0;
      end else begin
         addr_reg       <= addr_next;
         strap_done_reg <= 1'b1;
      end
   end

   srsb_cmd_dec u_dec (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .cmd_i     (cmd_i),
      .addr_i    (addr_reg),
      .dec_o     (dec)
   );

   // Data ready and display error bits gated by their enables
   always_comb begin
      set_vec = '0;
      // R6: data ready and display error gated
      // R19: data ready from output pending
      set_vec[srsb_pkg::BIT_DATA_RDY] = cond_i.data_ready & en_dr_reg;
      // R20: display error incl. command error
      set_vec[srsb_pkg::BIT_DISP_ERR] = (cond_i.disp_error
                                        | cond_i.cmd_error) & en_de_reg;
      // R5: command error needs no enable
      set_vec[srsb_pkg::BIT_CMD_ERR]  = cond_i.cmd_error;
      // R3: any set bit raises the summary
      // R4: nothing set, no summary
      set_vec[srsb_pkg::BIT_RQS]      = |set_vec;
   end

   // Clearing events for the whole word
   always_comb begin
      // R11: DCL always, SDC only when listening
      clear_msg = dec.dev_clear | (dec.sel_clear & listen_reg);
      // R10: SPD, Abort or untalk after sending
      clr_after = sent_reg & (dec.spd | ifc_sync
                  | ((dec.untalk | dec.other_talk)
                     & (talk_reg == srsb_pkg::TALK_ADDR)));
      // R12: each talk-only byte clears
      clr_all   = clear_msg | clr_after | (tonly_sync & data_out_i);
   end

   // Bus interface state next values
   always_comb begin
      talk_next   = talk_reg;
      listen_next = listen_reg;
      spms_next   = spms_reg;
      sent_next   = sent_reg;
      case (talk_reg)
         srsb_pkg::TALK_IDLE: begin
            if (dec.my_talk) begin
               talk_next = srsb_pkg::TALK_ADDR;
            end
         end
         srsb_pkg::TALK_ADDR: begin
            if (dec.untalk || dec.other_talk) begin
               talk_next = srsb_pkg::TALK_IDLE;
            end
         end
         default: talk_next = srsb_pkg::TALK_IDLE;
      endcase
      if (dec.my_listen) begin
         listen_next = 1'b1;
      end else if (dec.unlisten) begin
         listen_next = 1'b0;
      end
      if (dec.spe) begin
         spms_next = 1'b1;
      end else if (dec.spd) begin
         spms_next = 1'b0;
      end
      // R9: a taken poll byte marks it sent
      if (outv_reg && byte_sent_i) begin
         sent_next = 1'b1;
      end
      if (clr_all) begin
         sent_next = 1'b0;
      end
      // R14: IFC drops all addressing
      if (ifc_sync) begin
         talk_next   = srsb_pkg::TALK_IDLE;
         listen_next = 1'b0;
         spms_next   = 1'b0;
      end
   end

   // Status word and enables next values
   always_comb begin
      status_next = status_reg;
      en_dr_next  = en_dr_reg;
      en_de_next  = en_de_reg;
      if (enable_wr_i) begin
         en_dr_next = enable_data_rdy_i;
         en_de_next = enable_disp_err_i;
      end
      // R18: clear message drops enables
      if (clear_msg) begin
         en_dr_next = 1'b0;
         en_de_next = 1'b0;
      end
      // R7: bits stay until a full clear
      if (clr_all) begin
         status_next = srsb_pkg::STATUS_RESET;
      end
      // R8: frozen during poll mode; set wins
      if (!spms_reg) begin
         status_next = status_next | set_vec;
      end
      // R2: unused bits forced to zero
      status_next = status_next & srsb_pkg::STATUS_MASK;
   end

   // Outputs to the pins, registered from next state, in step with it
   always_comb begin
      // R9: word driven while polled talker
      outv_next = spms_next && !ifc_sync
                  && (talk_next == srsb_pkg::TALK_ADDR);
      // R17: SRQ let go once poll talk begins
      srq_oe_next = !(status_next[srsb_pkg::BIT_RQS] && !outv_next);
   end

   // Register every group; reset leaves word clear
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         // R21: cleared word, SRQ off, no poll
         talk_reg   <= srsb_pkg::TALK_IDLE;
         listen_reg <= 1'b0;
         spms_reg   <= 1'b0;
         sent_reg   <= 1'b0;
         status_reg <= srsb_pkg::STATUS_RESET;
         en_dr_reg  <= 1'b0;
         en_de_reg  <= 1'b0;
         srq_oe_reg <= 1'b1;
         out_reg    <= srsb_pkg::STATUS_RESET;
         outv_reg   <= 1'b0;
      end else begin
         talk_reg   <= talk_next;
         listen_reg <= listen_next;
         spms_reg   <= spms_next;
         sent_reg   <= sent_next;
         status_reg <= status_next;
         en_dr_reg  <= en_dr_next;
         en_de_reg  <= en_de_next;
         srq_oe_reg <= srq_oe_next;
         out_reg    <= status_next;
         outv_reg   <= outv_next;
      end
   end

   // R1: one 8-bit byte per poll
   assign status_byte_o  = out_reg;
   assign status_valid_o = outv_reg;
   assign talker_o       = (talk_reg == srsb_pkg::TALK_ADDR);
   assign listener_o     = listen_reg;
   assign spoll_mode_o   = spms_reg;
   assign srq_oe_o       = srq_oe_reg;
   // Open-drain line only ever pulled low
   assign srq_o          = 1'b0;
   // R13: parallel poll line never driven
   assign ppoll_oe_o     = 1'b1;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_quiet_set;
      !spms_reg && !clr_all && set_vec[srsb_pkg::BIT_RQS];
   endsequence

   property p_set_rqs;
      s_quiet_set |=> status_reg[srsb_pkg::BIT_RQS]
                      && (!srq_oe_o || outv_reg);
   endproperty
   a_set_rqs: assert property (p_set_rqs) // R3
      else $error("enabled condition did not request service");

   property p_gated;
      (cond_i.data_ready && !en_dr_reg && !spms_reg && !clr_all
       && !status_reg[srsb_pkg::BIT_DATA_RDY])
      |=> !status_reg[srsb_pkg::BIT_DATA_RDY];
   endproperty
   a_gated: assert property (p_gated) // R4
      else $error("disabled data ready set its bit");

   property p_cmd_err;
      (cond_i.cmd_error && !spms_reg)
      |=> status_reg[srsb_pkg::BIT_CMD_ERR]
          && status_reg[srsb_pkg::BIT_RQS];
   endproperty
   a_cmd_err: assert property (p_cmd_err) // R5
      else $error("command error did not set summary");

   property p_zero_bits;
      (status_byte_o & ~srsb_pkg::STATUS_MASK) == 8'h00;
   endproperty
   a_zero_bits: assert property (p_zero_bits) // R2
      else $error("reserved status bit set");

   property p_sticky;
      (status_reg != 8'h00 && !clr_all) |=> ($past(status_reg)
                                 & ~status_reg) == 8'h00;
   endproperty
   a_sticky: assert property (p_sticky) // R7
      else $error("status bit dropped without clear");

   property p_frozen;
      (spms_reg && !clr_all) |=> $stable(status_reg);
   endproperty
   a_frozen: assert property (p_frozen) // R8
      else $error("status changed during poll mode");

   sequence s_polled;
      spms_next && talk_next == srsb_pkg::TALK_ADDR && !ifc_sync;
   endsequence

   property p_poll_out;
      s_polled |=> status_valid_o && status_byte_o == status_reg
                   && srq_oe_o;
   endproperty
   a_poll_out: assert property (p_poll_out) // R17
      else $error("poll byte or SRQ release wrong");

   property p_clear;
      (clear_msg && !set_vec[srsb_pkg::BIT_RQS])
      |=> status_reg == 8'h00 && !en_dr_reg && !en_de_reg
          && srq_oe_o;
   endproperty
   a_clear: assert property (p_clear) // R11
      else $error("clear message left status or enables");

   property p_ifc;
      ifc_sync |=> !talker_o && !listener_o && !spoll_mode_o
                   ##1 !status_valid_o;
   endproperty
   a_ifc: assert property (p_ifc) // R14
      else $error("IFC did not unaddress");

   property p_tonly;
      (tonly_sync && data_out_i && !set_vec[srsb_pkg::BIT_RQS])
      |=> status_reg == 8'h00;
   endproperty
   a_tonly: assert property (p_tonly) // R12
      else $error("talk-only output did not clear word");
endmodule

//--- verif/service_request_status_byte_tb_top.sv
`timescale 1ns/1ps
module service_request_status_byte_tb_top;
   logic                 clk_sys_i = 1'b0;
   logic                 sys_rst_i = 1'b1;
   srsb_pkg::srsb_cmd_t  cmd;
   srsb_pkg::srsb_cond_t cond = '0;
   logic                 ifc, sent, sv, talk, lstn, spm;
   logic [4:0]           addr = srsb_pkg::ADDR_DEFAULT;
   logic                 tonly = 1'b0, wr = 1'b0, dout = 1'b0;
   logic                 en_d = 1'b0, en_e = 1'b0, sv_q = 1'b0;
   logic                 srq, srq_oe, pp_oe;
   logic [7:0]           sbyte;
   logic [7:0]           q[$];
   logic [7:0]           clr [2] = '{srsb_pkg::CMD_DCL,
                                     srsb_pkg::CMD_SDC};
   int                   num_errors = 0, n_compared = 0, cyc = 0;
   logic [31:0]          rnd = 32'hE0A41489;

   always #2.5 clk_sys_i = ~clk_sys_i;

   srsb_top srsb_top_inst (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd),
      .ifc_i(ifc), .addr_sw_i(addr), .talk_only_i(tonly),
      .cond_i(cond), .enable_wr_i(wr), .enable_data_rdy_i(en_d),
      .enable_disp_err_i(en_e), .byte_sent_i(sent),
      .data_out_i(dout), .status_byte_o(sbyte), .status_valid_o(sv),
      .talker_o(talk), .listener_o(lstn), .spoll_mode_o(spm),
      .srq_o(srq), .srq_oe_o(srq_oe), .ppoll_oe_o(pp_oe));

   srsb_ctl_model srsb_ctl_model_inst (
      .clk_sys_i(clk_sys_i), .sv_i(sv), .cmd_o(cmd),
      .ifc_o(ifc), .sent_o(sent));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic chk1(input logic a, input logic e);
      n_compared++;
      if (a !== e) begin
         num_errors++;
         $display("[FAIL] %0t flag %b exp %b", $time, a, e);
      end
   endtask

   task automatic chk8(input logic [7:0] a, input logic [7:0] e);
      n_compared++;
      if (a !== e) begin
         num_errors++;
         $display("[FAIL] %0t byte %h exp %h", $time, a, e);
      end
   endtask

   task automatic cy(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   task automatic tend(input string s);
      $display("test %s done at %0t", s, $time);
   endtask

   // Conditions {ready, cmd error, disp error} held one cycle
   task automatic cnd(input logic [2:0] c);
      @(posedge clk_sys_i);
      cond <= srsb_pkg::srsb_cond_t'(c);
      @(posedge clk_sys_i);
      cond <= '0;
      @(posedge clk_sys_i);
   endtask

   task automatic en(input logic d, input logic e);
      @(posedge clk_sys_i);
      wr <= 1'b1;
      en_d <= d;
      en_e <= e;
      @(posedge clk_sys_i);
      wr <= 1'b0;
   endtask

   // Poll with expected byte noted; k as in the controller model
   task automatic pl(input logic [4:0] a, input int k,
                     input logic [7:0] e);
      if (k == 2) begin
         srsb_ctl_model_inst.send({srsb_pkg::GRP_LISTEN, a});
         cy(1);
         chk1(lstn, 1'b1);
      end
      q.push_back(e);
      srsb_ctl_model_inst.poll(a, k);
      cy(1);
      chk8(sbyte, 8'h00);
      if (k != 0) chk1(talk, 1'b0);
      if (k == 2) chk1(lstn, 1'b0);
      srsb_ctl_model_inst.send(srsb_pkg::CMD_SPD);
      cy(1);
      chk1(spm, 1'b0);
   endtask

   // Watcher: each new poll byte against the oldest note
   always @(posedge clk_sys_i) begin
      sv_q <= sv;
      if (sv && !sv_q) begin
         if (q.size() == 0) begin
            num_errors++;
            $display("[FAIL] %0t unexpected poll byte", $time);
         end else begin
            chk8(sbyte, q.pop_front());
         end
         chk1(srq_oe, 1'b1);
      end
   end

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Hang guard, far above the few hundred cycles needed
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         $display("[FAIL] %0t timeout", $time);
         print_verdict();
      end
   end

   initial begin
      logic [31:0] r;
      logic [7:0]  e;
      cy(12);
      sys_rst_i <= 1'b0;
      cy(1);
      chk1(srq_oe, 1'b1);
      chk1(srq, 1'b0);
      chk1(pp_oe, 1'b1);
      chk1(spm, 1'b0);
      chk8(sbyte, 8'h00);
      cy(4);
      tend("reset");
      // Random enables and conditions, three poll endings
      for (int k = 0; k < 9; k++) begin
         rnd = lfsr(rnd);
         r = rnd;
         en(r[0], r[1]);
         cnd(r[4:2]);
         e = 8'h00;
         e[0] = r[4] & r[0];
         e[1] = r[3];
         e[2] = (r[2] | r[3]) & r[1];
         e[6] = |e[2:0];
         chk1(srq_oe, ~e[6]);
         pl(addr, k % 3, e);
      end
      tend("conditions");
      foreach (clr[i]) begin
         srsb_ctl_model_inst.send({srsb_pkg::GRP_LISTEN, addr});
         en(1'b1, 1'b1);
         cnd(3'b010);
         chk1(srq_oe, 1'b0);
         srsb_ctl_model_inst.send(clr[i]);
         cy(1);
         chk1(srq_oe, 1'b1);
         cnd(3'b101);
         pl(addr, 0, 8'h00);
      end
      tend("clear");
      // Untalk first, else SPE alone would start an unnoted poll byte
      srsb_ctl_model_inst.send(srsb_pkg::CMD_UNT);
      srsb_ctl_model_inst.send(srsb_pkg::CMD_SPE);
      cnd(3'b010);
      pl(addr, 0, 8'h00);
      chk1(srq_oe, 1'b1);
      tend("freeze");
      @(posedge clk_sys_i);
      tonly <= 1'b1;
      cy(4);
      cnd(3'b010);
      chk1(srq_oe, 1'b0);
      dout <= 1'b1;
      @(posedge clk_sys_i);
      dout <= 1'b0;
      cy(2);
      chk8(sbyte, 8'h00);
      chk1(srq_oe, 1'b1);
      tonly <= 1'b0;
      cy(4);
      tend("talk only");
      addr <= 5'h03;
      cy(5);
      // Start unaddressed so the new address must do the work
      srsb_ctl_model_inst.send(srsb_pkg::CMD_UNT);
      srsb_ctl_model_inst.send({srsb_pkg::GRP_TALK, 5'h03});
      cy(1);
      chk1(talk, 1'b1);
      srsb_ctl_model_inst.send({srsb_pkg::GRP_TALK, 5'h1C});
      cy(1);
      chk1(talk, 1'b0);
      cnd(3'b010);
      pl(5'h03, 1, 8'h42);
      tend("address");
      chk1(q.size() == 0, 1'b1);
      print_verdict();
   end
endmodule

//--- verif/srsb_ctl_model.sv
`timescale 1ns/1ps
// Controller side of the bus: commands, IFC, poll handshake
module srsb_ctl_model (
   input  wire logic           clk_sys_i,
   input  wire logic           sv_i,
   output srsb_pkg::srsb_cmd_t cmd_o,
   output logic                ifc_o,
   output logic                sent_o
);
   initial begin
      cmd_o = '0;
      ifc_o = 1'b0;
      sent_o = 1'b0;
   end

   // One command byte, valid for a single edge
   task automatic send(input logic [7:0] c);
      @(posedge clk_sys_i);
      cmd_o <= {1'b1, c};
      @(posedge clk_sys_i);
      // Idle code lines flip, so a stale byte never lingers
      cmd_o <= {1'b0, ~c};
   endtask

   // Serial poll; k picks the ending: 0 SPD, 1 untalk, 2 IFC
   task automatic poll(input logic [4:0] a, input int k);
      int n;
      n = 0;
      send(srsb_pkg::CMD_SPE);
      send({srsb_pkg::GRP_TALK, a});
      // Bounded wait for the byte on the lines
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (!sv_i && n < 20);
      sent_o <= 1'b1;
      @(posedge clk_sys_i);
      sent_o <= 1'b0;
      if (k == 0) send(srsb_pkg::CMD_SPD);
      if (k == 1) send(srsb_pkg::CMD_UNT);
      if (k == 2) begin
         ifc_o <= 1'b1;
         repeat (4) @(posedge clk_sys_i);
         ifc_o <= 1'b0;
      end
   endtask
endmodule
